/* bench/ext_irq_sense_sva.sv */
// Purpose: Port-level checks of the external interrupt sense block.
// Assumes: Register writes land at the APB access edge; pready is high.
// Notes:   Mask and lower sense are shadowed from bus writes.
`timescale 1ns/1ps
module ext_irq_sense_chk
  import ext_irq_pkg::*;
#(
  parameter int STARTUP_CYC = 4
) (
  input wire logic                 pclk,          // Clock
  input wire logic                 presetn,       // Reset, low
  input wire logic                 psel,          // APB select
  input wire logic                 penable,       // APB enable
  input wire logic                 pwrite,        // APB write
  input wire logic [ADDR_W-1:0]    paddr,         // APB address
  input wire logic [DATA_W-1:0]    pwdata,        // APB write data
  input wire logic [DATA_W-1:0]    prdata,        // APB read data
  input wire logic [EXT_LINES-1:0] ext_line,      // Request pins
  input wire logic                 cpu_global_ie, // Core enable
  input wire logic [EXT_LINES-1:0] ext_irq_ack,   // Service acks
  input wire logic                 sleep_req,     // Sleep entry
  input wire logic                 sleep_is_idle, // Idle sleep
  input wire irq_out_t             irq_out,       // Requests
  input wire logic                 io_clk_run     // I/O clock on
);
  logic [7:0] mask_sh;
  logic [7:0] low_sh;

  // Shadows follow the bus so no hierarchical peek is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sh <= 8'h00;
      low_sh  <= 8'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == {2'h0, IDX_MASK, 2'h0}) mask_sh <= pwdata[7:0];
      if (paddr == {2'h0, IDX_LOWER, 2'h0}) low_sh <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Five samples cover the two sync stages and the output register
  sequence s_low_held;
    (!ext_line[0] && mask_sh[0] && cpu_global_ie && io_clk_run &&
     low_sh[1:0] == 2'h0) [*5];
  endsequence
  sequence s_high_level;
    (ext_line[0] && low_sh[1:0] == 2'h0) [*5];
  endsequence
  sequence s_ack_held;
    (ext_irq_ack[0] && $stable(ext_line[0]) && low_sh[1:0] != 2'h0) [*6];
  endsequence

  property p_level_req; s_low_held |-> irq_out.ext[0]; endproperty
  property p_level_off; s_high_level |-> !irq_out.ext[0]; endproperty
  property p_ack_clr; s_ack_held |-> !irq_out.ext[0]; endproperty
  property p_ie_gate; !cpu_global_ie |=> irq_out.ext == 8'h00; endproperty
  property p_mask_gate;
    (irq_out.ext & ~$past(mask_sh)) == 8'h00;
  endproperty
  property p_sleep_clk;
    $rose(sleep_req) && io_clk_run |=> (sleep_is_idle || !io_clk_run);
  endproperty
  property p_idle_clk; sleep_is_idle [*8] |-> io_clk_run; endproperty
  property p_rdata_hi; prdata[31:8] == 24'h000000; endproperty

  a_level_req: assert property (p_level_req)
    else $error("level request missing");
  a_level_off: assert property (p_level_off)
    else $error("request with level released");
  a_ack_clr: assert property (p_ack_clr)
    else $error("request survives service ack");
  a_ie_gate: assert property (p_ie_gate)
    else $error("request without global enable");
  a_mask_gate: assert property (p_mask_gate)
    else $error("request on masked line");
  a_sleep_clk: assert property (p_sleep_clk)
    else $error("io clock runs in deep sleep");
  a_idle_clk: assert property (p_idle_clk)
    else $error("io clock stopped in idle");
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("read data above byte not zero");
endmodule

bind ext_irq_sense ext_irq_sense_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .ext_line, .cpu_global_ie, .ext_irq_ack, .sleep_req, .sleep_is_idle,
  .irq_out, .io_clk_run
);

/* bench/ext_pin_source.sv */
// Purpose: Outside sources driving the request and pin-change pins.
// Assumes: Tasks are called just after a rising clock edge.
// Notes:   Pins are push-pull levels; no pull or float is modelled.
`timescale 1ns/1ps
module ext_pin_source
  import ext_irq_pkg::*;
(
  input  wire logic                 pclk,            // Bench clock
  output      logic [EXT_LINES-1:0] ext_line,        // Request pins
  output      logic [PC_LINES-1:0]  pin_change_line  // Pin-change pins
);
  // Both pin groups idle low from time zero
  initial begin
    ext_line = 8'h00;
    pin_change_line = 13'h0000;
  end

  // Levels change just after an edge, as a real source would
  task automatic set_ext(input int i, input logic v);
    @(posedge pclk);
    ext_line[i] <= v;
  endtask
  task automatic set_pc(input int i, input logic v);
    @(posedge pclk);
    pin_change_line[i] <= v;
  endtask
  // Pulse held a whole number of cycles so sampling cannot miss it
  task automatic pulse_ext(input int i, input int w);
    @(posedge pclk);
    ext_line[i] <= ~ext_line[i];
    repeat (w) @(posedge pclk);
    ext_line[i] <= ~ext_line[i];
  endtask
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench of the external interrupt sense block.
// Assumes: Zero-wait APB slave; start-up shortened to four cycles.
// Notes:   Sense cases run from a table; the rest are hand-written.
`timescale 1ns/1ps
module tb_top;
  import ext_irq_pkg::*;
  typedef struct packed {
    logic [1:0] sel; // Sense select
    logic [3:0] lv;  // Start level, end level, flag, request
  } row_t;
  row_t rows [6] = '{'{SENSE_LOW, 4'h9}, '{SENSE_ANY, 4'h7},
    '{SENSE_FALL, 4'hB}, '{SENSE_FALL, 4'h4}, '{SENSE_RISE, 4'h7},
    '{SENSE_RISE, 4'h8}};
  int lines [2] = '{0, 5};
  logic [7:0] regs [8] = '{IDX_PC_FLAG, IDX_FLAG, IDX_MASK, IDX_PC_CTRL,
    IDX_LOWER, IDX_UPPER, IDX_PC_MASK0, IDX_PC_MASK1};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic cpu_global_ie, sleep_req, sleep_is_idle, io_clk_run;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [EXT_LINES-1:0] ext_line, ext_irq_ack;
  logic [PC_LINES-1:0] pin_change_line;
  logic [1:0] pc_irq_ack;
  irq_out_t irq_out;
  int num_errors, n_compared;

  ext_irq_sense #(.STARTUP_CYC(4)) u_ext_irq_sense (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_line, .pin_change_line, .cpu_global_ie, .ext_irq_ack, .pc_irq_ack,
    .sleep_req, .sleep_is_idle, .irq_out, .io_clk_run);
  ext_pin_source u_ext_pin_source (.pclk, .ext_line, .pin_change_line);

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_compared++;
    if (got !== ex) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rdat,
                     output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err  = pslverr;
    if (n >= 20) num_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] ex,
                    input string nm);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 8'h00, d, e);
    chk(nm, ex, d);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    wt(3);
    presetn <= 1'b1;
    wt(1);
  endtask

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    wt(20000);
    num_errors++;
    end_of_test();
  end

  initial begin
    row_t        row;
    int          ln;
    int          n;
    logic [31:0] d;
    logic        e;
    {psel, penable, pwrite, sleep_req, sleep_is_idle} = 5'h00;
    {paddr, pwdata, ext_irq_ack, pc_irq_ack} = '0;
    cpu_global_ie = 1'b0;
    presetn = 1'b0;
    do_reset();
    cpu_global_ie <= 1'b1;
    // Sense table, reconfigured in the safe order each time
    foreach (lines[k]) for (int r = 0; r < 6; r++) begin
      ln  = lines[k];
      row = rows[r];
      wr(IDX_MASK, 8'h00);
      wr(ln < 4 ? IDX_LOWER : IDX_UPPER, 8'(row.sel) << (2 * (ln % 4)));
      u_ext_pin_source.set_ext(ln, row.lv[3]);
      wt(6);
      wr(IDX_FLAG, 8'hFF);
      wr(IDX_MASK, 8'h01 << ln);
      u_ext_pin_source.set_ext(ln, row.lv[2]);
      wt(6);
      rd(IDX_FLAG, 32'(row.lv[1]) << ln, "flag");
      chk("req", 32'(row.lv[0]), 32'(irq_out.ext[ln]));
      cpu_global_ie <= 1'b0;
      wt(2);
      chk("ie", 32'h0, 32'(irq_out.ext[ln]));
      cpu_global_ie <= 1'b1;
    end
    // Reset in mid-run, then reset values and access kinds
    do_reset();
    foreach (regs[i]) rd(regs[i], 32'h0, "reset");
    wr(IDX_UPPER, 8'hA5);
    rd(IDX_UPPER, 32'hA5, "upper");
    apb(1'b0, 8'hFF, 8'h00, d, e);
    chk("unmapped", 32'h1, {d[30:0], e});
    // Pin-change groups and their masks
    wr(IDX_PC_MASK0, 8'h01);
    wr(IDX_PC_MASK1, 8'h10);
    wr(IDX_PC_CTRL, 8'h03);
    u_ext_pin_source.set_pc(1, 1'b1);
    wt(6);
    chk("grp", 32'h0, 32'({irq_out.grp1, irq_out.grp0}));
    u_ext_pin_source.set_pc(0, 1'b1);
    wt(6);
    chk("grp", 32'h1, 32'({irq_out.grp1, irq_out.grp0}));
    u_ext_pin_source.set_pc(12, 1'b1);
    wt(6);
    chk("grp", 32'h3, 32'({irq_out.grp1, irq_out.grp0}));
    pc_irq_ack <= 2'h2;
    wt(2);
    pc_irq_ack <= 2'h0;
    rd(IDX_PC_FLAG, 32'h1, "pcack");
    wr(IDX_PC_FLAG, 8'h01);
    rd(IDX_PC_FLAG, 32'h0, "pcw1c");
    // Two-cycle pulses, service ack and write-one clear
    wr(IDX_LOWER, 8'h01);
    wr(IDX_UPPER, 8'h01);
    wr(IDX_MASK, 8'h01);
    u_ext_pin_source.pulse_ext(0, 2);
    u_ext_pin_source.pulse_ext(4, 2);
    wt(6);
    rd(IDX_FLAG, 32'h11, "pulse");
    ext_irq_ack <= 8'h01;
    wt(8);
    ext_irq_ack <= 8'h00;
    rd(IDX_FLAG, 32'h10, "ack");
    wr(IDX_FLAG, 8'h10);
    rd(IDX_FLAG, 32'h0, "w1c");
    // Deep sleep: upper edges ignored, pin change wakes
    sleep_req <= 1'b1;
    wt(1);
    sleep_req <= 1'b0;
    wt(1);
    chk("ioclk", 32'h0, 32'(io_clk_run));
    u_ext_pin_source.pulse_ext(4, 3);
    wt(4);
    chk("asleep", 32'h0, 32'(io_clk_run));
    u_ext_pin_source.set_pc(0, 1'b0);
    n = 0;
    while (irq_out.wake !== 1'b1 && n < 20) begin
      wt(1);
      n++;
    end
    chk("wake", 32'h1, 32'(irq_out.wake));
    n = 0;
    while (io_clk_run !== 1'b1 && n < 40) begin
      wt(1);
      n++;
    end
    rd(IDX_FLAG, 32'h0, "upper asleep");
    rd(IDX_PC_FLAG, 32'h1, "pcwake");
    // Clear the group flags first, or they would wake idle sleep at once
    wr(IDX_PC_FLAG, 8'h03);
    // Idle sleep keeps the I/O clock, so upper edges still register
    sleep_is_idle <= 1'b1;
    sleep_req <= 1'b1;
    wt(1);
    sleep_req <= 1'b0;
    wt(2);
    u_ext_pin_source.pulse_ext(4, 2);
    wt(6);
    chk("idle", 32'h1, 32'(io_clk_run));
    rd(IDX_FLAG, 32'h10, "idle edge");
    sleep_is_idle <= 1'b0;
    wt(2);
    end_of_test();
  end
endmodule

/* rtl/ext_irq_pkg.sv */
// Purpose: Shared constants, types and helpers of the external interrupt
//          sense block.
// Assumes: 125 MHz pclk; registers reached over APB by word index.
// Notes:   Byte address of a register is its index shifted left by two.
package ext_irq_pkg;

  // Bus geometry
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam int          IDX_W      = ADDR_W - 2;

  // Register indices
  localparam logic [7:0]  IDX_PC_FLAG  = 8'h1B;
  localparam logic [7:0]  IDX_FLAG     = 8'h1C;
  localparam logic [7:0]  IDX_MASK     = 8'h1D;
  localparam logic [7:0]  IDX_PC_CTRL  = 8'h68;
  localparam logic [7:0]  IDX_LOWER    = 8'h69;
  localparam logic [7:0]  IDX_UPPER    = 8'h6A;
  localparam logic [7:0]  IDX_PC_MASK0 = 8'h6B;
  localparam logic [7:0]  IDX_PC_MASK1 = 8'h6C;

  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [4:0]  RST_MASK1  = 5'h00;
  localparam logic [1:0]  RST_PAIR   = 2'h0;

  // Line counts and field positions
  localparam int          EXT_LINES  = 8;
  localparam int          LOW_LINES  = 4;
  localparam int          PC_LINES   = 13;
  localparam int          PC_G0_W    = 8;
  localparam int          PC_G1_W    = PC_LINES - PC_G0_W;
  localparam int          FLD_GRP0   = 0;
  localparam int          FLD_GRP1   = 1;

  // Start-up time after a deep sleep wake
  localparam int          CLK_MHZ         = 125;
  localparam int          STARTUP_TIME_NS = 1000;
  localparam int          STARTUP_CYCLES  =
    (STARTUP_TIME_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE
  } sense_t;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_STARTUP} pwr_state_t;

  // Requests presented to the core
  typedef struct packed {
    logic [EXT_LINES-1:0] ext;     // Per-line external requests
    logic                 grp1;    // Pin-change group 1 request
    logic                 grp0;    // Pin-change group 0 request
    logic                 wake;    // Wake pulse out of sleep
  } irq_out_t;

  // Edge match of one line for its two-bit sense select
  function automatic logic sense_hit(input logic [1:0] sel,
                                     input logic       prev,
                                     input logic       cur);
    unique case (sense_t'(sel))
      SENSE_LOW:  sense_hit = 1'b0;
      SENSE_ANY:  sense_hit = prev ^ cur;
      SENSE_FALL: sense_hit = prev & ~cur;
      SENSE_RISE: sense_hit = ~prev & cur;
    endcase
  endfunction

  // Word index decode of an APB byte address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        idx);
    reg_hit = (addr[ADDR_W-1:2] == IDX_W'(idx)) && (addr[1:0] == 2'h0);
  endfunction

endpackage

/* rtl/ext_irq_sense.sv */
// Purpose: Sense logic for eight external interrupt lines and thirteen
//          pin-change lines, with APB registers and sleep wake-up.
// Assumes: pclk stands for the always-on core clock; the I/O clock is
//          modelled by io_clk_run, which gates the sampled upper lines.
// Notes:   All pins are synchronised by two flip-flops before use.
//
// Summary of operation
// - Requests come from pin levels, whatever the pin direction is.
// - Group 0 requests when an enabled pin-change line 7:0 toggles.
// - Group 1 requests when an enabled pin-change line 12:8 toggles.
// - Pin changes are seen without the I/O clock and wake any sleep.
// - Enabled low-level line requests for as long as pin stays low.
// - Edges on lines 7:4 are seen only while the I/O clock runs.
// - Low levels and edges on lines 3:0 need no I/O clock; they wake.
// - I/O clock stops in every sleep except idle.
// - Level lost before start-up ends: wake still, but no request.
// - Line request reaches core only with global enable and mask set.
// - Lines 3:0 sense: low, any edge, falling, rising.
// - Lines 7:4 sense: low, any change, falling, rising between samples.
// - Lines 7:4 sampled on clock; pulses over one period are caught.
// - Edges on lines 3:0 are registered without the I/O clock.
// - Upper sense register: line 7 in bits 7:6 to line 4; reset zero.
// - Flags set on trigger, clear on service or write one; zero in level.
// - One mask bit per external line, reset to zero.
// - One mask bit per pin-change line selects its group contribution.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

module ext_irq_sense #(
  parameter int STARTUP_CYC = ext_irq_pkg::STARTUP_CYCLES
) (
  input  wire logic                            pclk,          // Clock
  input  wire logic                            presetn,       // Reset, low
  input  wire logic                            psel,          // APB select
  input  wire logic                            penable,       // APB enable
  input  wire logic                            pwrite,        // APB write
  input  wire logic [ext_irq_pkg::ADDR_W-1:0]  paddr,         // APB address
  input  wire logic [ext_irq_pkg::DATA_W-1:0]  pwdata,        // APB wdata
  output      logic [ext_irq_pkg::DATA_W-1:0]  prdata,        // APB rdata
  output      logic                            pready,        // APB ready
  output      logic                            pslverr,       // Unmapped
  input  wire logic [ext_irq_pkg::EXT_LINES-1:0] ext_line,    // Ext pins
  input  wire logic [ext_irq_pkg::PC_LINES-1:0]  pin_change_line, // PC pins
  input  wire logic                            cpu_global_ie, // Core I-bit
  input  wire logic [ext_irq_pkg::EXT_LINES-1:0] ext_irq_ack, // Serviced
  input  wire logic [1:0]                      pc_irq_ack,    // Serviced
  input  wire logic                            sleep_req,     // Enter sleep
  input  wire logic                            sleep_is_idle, // Idle mode
  output      ext_irq_pkg::irq_out_t           irq_out,       // Requests
  output      logic                            io_clk_run     // I/O clock
);
  import ext_irq_pkg::*;

  // Pin synchronisers and previous samples
  logic [EXT_LINES-1:0] ext_meta_reg;
  logic [EXT_LINES-1:0] ext_sync_reg;
  logic [EXT_LINES-1:0] ext_prev_reg;
  logic [PC_LINES-1:0]  pc_meta_reg;
  logic [PC_LINES-1:0]  pc_sync_reg;
  logic [PC_LINES-1:0]  pc_prev_reg;

  // Software registers
  logic [7:0]           lower_reg;
  logic [7:0]           upper_reg;
  logic [7:0]           mask_reg;
  logic [7:0]           flag_reg;
  logic [7:0]           flag_next;
  logic [PC_G0_W-1:0]   pc_mask0_reg;
  logic [PC_G1_W-1:0]   pc_mask1_reg;
  logic [1:0]           pc_ctrl_reg;
  logic [1:0]           pc_flag_reg;
  logic [1:0]           pc_flag_next;

  // Sleep and start-up sequencing
  pwr_state_t           pwr_reg;
  pwr_state_t           pwr_next;
  logic [15:0]          startup_cnt_reg;
  logic                 startup_busy;
  logic                 wake_evt;

  // Detection terms
  logic [15:0]          sense_sel;
  logic [EXT_LINES-1:0] level_mode;
  logic [EXT_LINES-1:0] edge_set;
  logic [EXT_LINES-1:0] level_req;
  logic [EXT_LINES-1:0] ext_req;
  logic [1:0]           pc_hit;
  logic [1:0]           pc_req;
  irq_out_t             irq_next;

  // Bus strobes
  logic                 wr_en;
  logic                 rd_setup;
  logic                 mapped;
  logic [7:0]           wbyte;
  logic [7:0]           rd_mux;

  // Two flip-flops on every pin; only the second stage feeds logic.
  // Pin direction plays no part, so software can drive its own pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_reg <= RST_BYTE;
      ext_sync_reg <= RST_BYTE;
      pc_meta_reg  <= '0;
      pc_sync_reg  <= '0;
    end else begin
      ext_meta_reg <= ext_line;
      ext_sync_reg <= ext_meta_reg;
      pc_meta_reg  <= pin_change_line;
      pc_sync_reg  <= pc_meta_reg;
    end
  end

  // Lower lines and pin changes are watched on the core clock, which
  // keeps running in sleep; the upper lines only sample on I/O clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg <= RST_BYTE;
      pc_prev_reg  <= '0;
    end else begin
      ext_prev_reg[LOW_LINES-1:0] <= ext_sync_reg[LOW_LINES-1:0];
      pc_prev_reg                 <= pc_sync_reg;
      if (io_clk_run) begin
        ext_prev_reg[EXT_LINES-1:LOW_LINES] <=
          ext_sync_reg[EXT_LINES-1:LOW_LINES];
      end
    end
  end

  // Sense decode per line
  assign sense_sel = {upper_reg, lower_reg};

  always_comb begin
    for (int i = 0; i < EXT_LINES; i++) begin
      level_mode[i] = (sense_sel[2*i +: 2] == 2'(SENSE_LOW));
      // Lower lines: edge found on the always-running core clock
      if (i < LOW_LINES) begin
        edge_set[i] = sense_hit(sense_sel[2*i +: 2], ext_prev_reg[i],
                                ext_sync_reg[i]);
      end else begin
        // Upper lines: frozen while the I/O clock is stopped
        edge_set[i] = io_clk_run &
                      sense_hit(sense_sel[2*i +: 2], ext_prev_reg[i],
                                ext_sync_reg[i]);
      end
      // A level lost during start-up leaves no request behind
      level_req[i] = level_mode[i] & ~ext_sync_reg[i] &
                     ~startup_busy;
    end
  end

  // Pin-change toggles per group through the per-pin masks
  assign pc_hit[0] = |((pc_sync_reg[PC_G0_W-1:0] ^
                        pc_prev_reg[PC_G0_W-1:0]) & pc_mask0_reg);
  assign pc_hit[1] = |((pc_sync_reg[PC_LINES-1:PC_G0_W] ^
                        pc_prev_reg[PC_LINES-1:PC_G0_W]) &
                       pc_mask1_reg);

  // APB strobes; the slave never inserts wait states
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte    = pwdata[7:0];
  assign pready   = 1'b1;
  assign mapped   = reg_hit(paddr, IDX_PC_FLAG) | reg_hit(paddr, IDX_FLAG) |
                    reg_hit(paddr, IDX_MASK)    | reg_hit(paddr, IDX_PC_CTRL) |
                    reg_hit(paddr, IDX_LOWER)   | reg_hit(paddr, IDX_UPPER) |
                    reg_hit(paddr, IDX_PC_MASK0) | reg_hit(paddr, IDX_PC_MASK1);
  assign pslverr  = psel & penable & ~mapped;

  // Sense, mask and group control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_reg    <= RST_BYTE;
      upper_reg    <= RST_BYTE;
      mask_reg     <= RST_BYTE;
      pc_mask0_reg <= RST_BYTE;
      pc_mask1_reg <= RST_MASK1;
      pc_ctrl_reg  <= RST_PAIR;
    end else if (wr_en) begin
      if (reg_hit(paddr, IDX_LOWER))    lower_reg    <= wbyte;
      if (reg_hit(paddr, IDX_UPPER))    upper_reg    <= wbyte;
      if (reg_hit(paddr, IDX_MASK))     mask_reg     <= wbyte;
      if (reg_hit(paddr, IDX_PC_MASK0)) pc_mask0_reg <= wbyte;
      if (reg_hit(paddr, IDX_PC_MASK1)) begin
        pc_mask1_reg <= wbyte[PC_G1_W-1:0];
      end
      if (reg_hit(paddr, IDX_PC_CTRL))  pc_ctrl_reg  <= wbyte[1:0];
    end
  end

  // Flags: a new trigger beats a clear in the same cycle, so no event
  // is lost; level-mode lines keep their flag at zero.
  always_comb begin
    logic [7:0] clr;
    logic [1:0] pclr;
    clr  = ext_irq_ack;
    pclr = pc_irq_ack;
    if (wr_en && reg_hit(paddr, IDX_FLAG))    clr  = clr | wbyte;
    if (wr_en && reg_hit(paddr, IDX_PC_FLAG)) pclr = pclr | wbyte[1:0];
    flag_next    = ((flag_reg & ~clr) | edge_set) & ~level_mode;
    pc_flag_next = (pc_flag_reg & ~pclr) | pc_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg    <= RST_BYTE;
      pc_flag_reg <= RST_PAIR;
    end else begin
      flag_reg    <= flag_next;
      pc_flag_reg <= pc_flag_next;
    end
  end

  // Requests to the core need the global enable and the line's mask
  assign ext_req = (flag_reg | level_req) & mask_reg;
  assign pc_req  = pc_flag_reg & pc_ctrl_reg;

  // Wake sources: masked low levels, lower edges and pin changes work
  // without the I/O clock; in idle the upper edges can wake as well.
  assign wake_evt = (|(level_mode & ~ext_sync_reg & mask_reg)) |
                    (|ext_req[LOW_LINES-1:0])                  |
                    (sleep_is_idle & (|ext_req))               |
                    (|pc_req);

  // Sleep sequencing; a deep sleep wake passes through start-up
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_RUN: begin
        if (sleep_req) pwr_next = PWR_SLEEP;
      end
      PWR_SLEEP: begin
        if (wake_evt) pwr_next = sleep_is_idle ? PWR_RUN : PWR_STARTUP;
      end
      PWR_STARTUP: begin
        if (startup_cnt_reg == 16'(STARTUP_CYC - 1)) pwr_next = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= PWR_RUN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // Start-up counter; levels are only honoured after it expires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_cnt_reg <= 16'h0000;
    end else if (pwr_reg == PWR_STARTUP) begin
      startup_cnt_reg <= startup_cnt_reg + 16'h0001;
    end else begin
      startup_cnt_reg <= 16'h0000;
    end
  end

  assign startup_busy = (pwr_reg == PWR_STARTUP);

  // The I/O clock runs awake and in idle only
  assign io_clk_run = (pwr_reg == PWR_RUN) ||
                      ((pwr_reg == PWR_SLEEP) && sleep_is_idle);

  // Registered request outputs
  always_comb begin
    irq_next      = '0;
    irq_next.ext  = ext_req & {EXT_LINES{cpu_global_ie}};
    irq_next.grp0 = pc_req[FLD_GRP0] & cpu_global_ie;
    irq_next.grp1 = pc_req[FLD_GRP1] & cpu_global_ie;
    irq_next.wake = (pwr_reg == PWR_SLEEP) && wake_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out <= '0;
    end else begin
      irq_out <= irq_next;
    end
  end

  // Read mux; reads show live flags and the register contents
  always_comb begin
    rd_mux = RST_BYTE;
    if (reg_hit(paddr, IDX_LOWER))    rd_mux = lower_reg;
    if (reg_hit(paddr, IDX_UPPER))    rd_mux = upper_reg;
    if (reg_hit(paddr, IDX_MASK))     rd_mux = mask_reg;
    if (reg_hit(paddr, IDX_FLAG))     rd_mux = flag_reg;
    if (reg_hit(paddr, IDX_PC_MASK0)) rd_mux = pc_mask0_reg;
    if (reg_hit(paddr, IDX_PC_MASK1)) rd_mux = {3'h0, pc_mask1_reg};
    if (reg_hit(paddr, IDX_PC_CTRL))  rd_mux = {6'h00, pc_ctrl_reg};
    if (reg_hit(paddr, IDX_PC_FLAG))  rd_mux = {6'h00, pc_flag_reg};
  end

  // Read data is captured in the setup cycle so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end

endmodule
